// file: core/ghup_port.sv
// Purpose: host serial port and timing pulse of a navigation receiver
// Assumes: one clock; reset pin synchronised here; sentence text supplied by engine
// Notes: no handshake lines; rate change takes effect at next bit period, also inside a character
`timescale 1ns/100ps
`include "ghup_map.svh"
module ghup_port import ghup_pkg::*; #(
   parameter int PPS_CYCLES = `GHUP_PPS_CYCLES,
   parameter int PPS_HIGH_CYCLES = `GHUP_PPS_HIGH_CYCLES
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic reset_in_low_i,
   input wire logic host_transmit_line_i,
   output logic host_receive_line_o,
   input wire logic [2:0] rate_sel_i,
   input wire logic rate_load_i,
   input wire logic [7:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   output logic [7:0] cmd_data_o,
   output logic cmd_valid_o,
   output logic cmd_frame_err_o,
   input wire logic fix_3d_i,
   input wire logic [3:0] sat_count_i,
   input wire logic utc_second_i,
   output logic pps_o,
   output logic engine_reset_n_o
);
   logic rst_s1_reg, rst_s2_reg, rx_s1_reg, rx_s2_reg;
   logic run_n;
   logic [2:0] rate_reg, rate_next;
   ghup_div_t div;
   ghup_state_e tst_reg, tst_next;
   ghup_div_t tcnt_reg, tcnt_next;
   logic [2:0] tbit_reg, tbit_next;
   logic [7:0] tsh_reg, tsh_next;
   logic line_reg, line_next;
   logic rdy_reg, rdy_next;
   logic [7:0] rx_data;
   logic rx_valid, rx_err;
   logic [7:0] cmd_reg, cmd_next;
   logic cmdv_reg, cmdv_next, cmde_reg, cmde_next;
   logic [31:0] pcnt_reg, pcnt_next;
   logic pps_reg, pps_next;
   logic fix_ok;

   // RULE10: open reset pin reads high via pad pull-up, runs normally
   // RULE12: low on reset pin holds the block
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
         rx_s1_reg <= 1'b1;
         rx_s2_reg <= 1'b1;
      end else begin
         rst_s1_reg <= reset_in_low_i;
         rst_s2_reg <= rst_s1_reg;
         rx_s1_reg <= host_transmit_line_i;
         rx_s2_reg <= rx_s1_reg;
      end
   end
   assign run_n = nrst_i & rst_s2_reg;

   // RULE1: rate select from supported set
   // RULE2: reset rate 115200 8n1
   always_comb begin
      rate_next = rate_reg;
      if (rate_load_i && rate_sel_i != 3'h7) begin
         rate_next = rate_sel_i;
      end
   end
   assign div = ghup_rate_div(rate_reg);

   // RULE4: sentence bytes out on transmit line
   // RULE3: bit rate pacing only, no handshake
   always_comb begin
      tst_next = tst_reg;
      tcnt_next = tcnt_reg;
      tbit_next = tbit_reg;
      tsh_next = tsh_reg;
      line_next = line_reg;
      rdy_next = 1'b0;
      case (tst_reg)
         ghup_idle: begin
            line_next = 1'b1;
            rdy_next = 1'b1;
            if (tx_valid_i && rdy_reg) begin
               // RULE11: start bit low
               tst_next = ghup_start;
               tsh_next = tx_data_i;
               tcnt_next = div - 16'h0001;
               line_next = 1'b0;
               rdy_next = 1'b0;
            end
         end
         ghup_start: begin
            if (tcnt_reg != '0) begin
               tcnt_next = tcnt_reg - 16'h0001;
            end else begin
               tst_next = ghup_data;
               tcnt_next = div - 16'h0001;
               tbit_next = 3'h0;
               line_next = tsh_reg[0];
               tsh_next = {1'b1, tsh_reg[7:1]};
            end
         end
         ghup_data: begin
            if (tcnt_reg != '0) begin
               tcnt_next = tcnt_reg - 16'h0001;
            end else begin
               tcnt_next = div - 16'h0001;
               tbit_next = tbit_reg + 3'h1;
               if (tbit_reg == 3'h7) begin
                  // RULE11: stop bit high
                  tst_next = ghup_stop;
                  line_next = 1'b1;
               end else begin
                  line_next = tsh_reg[0];
                  tsh_next = {1'b1, tsh_reg[7:1]};
               end
            end
         end
         ghup_stop: begin
            if (tcnt_reg != '0) begin
               tcnt_next = tcnt_reg - 16'h0001;
            end else begin
               tst_next = ghup_idle;
               rdy_next = 1'b1;
            end
         end
         default: tst_next = ghup_idle;
      endcase
   end

   // RULE7: pulse gated by 3d fix and satellite count
   assign fix_ok = fix_3d_i && (sat_count_i >= `GHUP_MIN_SATS);
   always_comb begin
      pcnt_next = pcnt_reg;
      pps_next = pps_reg;
      if (!fix_ok) begin
         // RULE8: no fix, hold low
         pcnt_next = '0;
         pps_next = 1'b0;
      end else if (utc_second_i) begin
         // RULE7: rising edge on utc second
         pcnt_next = 32'(PPS_HIGH_CYCLES - 1);
         pps_next = 1'b1;
      end else if (pcnt_reg != '0) begin
         pcnt_next = pcnt_reg - 32'h0000_0001;
      end else begin
         pps_next = 1'b0;
      end
   end

   // a run reset, pin or system, brings the port back to its power-up rate
   always_ff @(posedge clk_i) begin
      if (!run_n) begin
         rate_reg <= `GHUP_RATE_RESET;
      end else begin
         rate_reg <= rate_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!run_n) begin
         tst_reg <= ghup_idle;
         tcnt_reg <= '0;
         tbit_reg <= 3'h0;
         tsh_reg <= 8'h00;
         line_reg <= 1'b1;
         rdy_reg <= 1'b0;
      end else begin
         tst_reg <= tst_next;
         tcnt_reg <= tcnt_next;
         tbit_reg <= tbit_next;
         tsh_reg <= tsh_next;
         line_reg <= line_next;
         rdy_reg <= rdy_next;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!run_n) begin
         pcnt_reg <= '0;
         pps_reg <= 1'b0;
      end else begin
         pcnt_reg <= pcnt_next;
         pps_reg <= pps_next;
      end
   end

   // last good byte is kept; a framing error only pulses its flag
   always_comb begin
      cmd_next = rx_valid ? rx_data : cmd_reg;
      cmdv_next = rx_valid;
      cmde_next = rx_err;
   end

   always_ff @(posedge clk_i) begin
      if (!run_n) begin
         cmd_reg <= 8'h00;
         cmdv_reg <= 1'b0;
         cmde_reg <= 1'b0;
      end else begin
         cmd_reg <= cmd_next;
         cmdv_reg <= cmdv_next;
         cmde_reg <= cmde_next;
      end
   end

   // RULE4: command bytes in on receive line
   // RULE6: device input from host transmit
   ghup_rx u_rx (
      .clk_i(clk_i),
      .nrst_i(run_n),
      .line_i(rx_s2_reg),
      .div_i(div),
      .data_o(rx_data),
      .valid_o(rx_valid),
      .frame_err_o(rx_err)
   );

   // RULE6: device output to host receive
   assign host_receive_line_o = line_reg;
   assign tx_ready_o = rdy_reg;
   assign cmd_data_o = cmd_reg;
   assign cmd_valid_o = cmdv_reg;
   assign cmd_frame_err_o = cmde_reg;
   assign pps_o = pps_reg;
   // RULE9: retained state lives in backup domain, engine reset only
   // RULE5: engine emits default sentence set after this release
   assign engine_reset_n_o = rst_s2_reg;
endmodule : ghup_port

// file: core/ghup_map.svh
// Purpose: constants for the host serial port and timing pulse block
// Assumes: 125 MHz clock, 8 ns period
// Notes: rate divisors are rounded to the nearest whole cycle
// Contract
// RULE1: port runs at 9600 to 2000000 bps; both ends at one rate.
// RULE2: after reset the rate is 115200, eight data bits, no parity, one stop.
// RULE3: no handshake lines, no clocked mode; pacing by bit rate only.
// RULE4: navigation text goes out on transmit; commands come in on receive.
// RULE5: default sentence set is emitted with no prior command.
// RULE6: device output feeds host receive; host transmit feeds device input.
// RULE7: with 3D fix on four or more satellites, one pulse per second.
// RULE8: with no fix the timing pulse stays low.
// RULE9: backup supply keeps memory and clock; retained state speeds next fix.
// RULE10: reset input may be driven by host or left open.
// RULE11: start bit low, data LSB first, stop bit high, idle high.
// RULE12: reset input is active low.
`ifndef GHUP_MAP_SVH
`define GHUP_MAP_SVH
`define GHUP_CLK_HZ 125000000
`define GHUP_DIV_9600 16'h32DD
`define GHUP_DIV_38400 16'h0CB7
`define GHUP_DIV_115200 16'h043D
`define GHUP_DIV_230400 16'h021F
`define GHUP_DIV_460800 16'h010F
`define GHUP_DIV_1000000 16'h007D
`define GHUP_DIV_2000000 16'h003F
`define GHUP_RATE_RESET 3'h2
`define GHUP_DATA_BITS 8
`define GHUP_PPS_PERIOD_S 1
`define GHUP_PPS_CYCLES (`GHUP_CLK_HZ * `GHUP_PPS_PERIOD_S)
`define GHUP_PPS_HIGH_MS 100
`define GHUP_PPS_HIGH_CYCLES (`GHUP_CLK_HZ / 1000 * `GHUP_PPS_HIGH_MS)
`define GHUP_MIN_SATS 4'h4
`endif

// file: core/ghup_pkg.sv
// Purpose: types for the host serial port block
// Assumes: constants come from ghup_map.svh
// Notes: none
`include "ghup_map.svh"
package ghup_pkg;
   typedef enum logic [1:0] {ghup_idle, ghup_start, ghup_data, ghup_stop} ghup_state_e;
   typedef logic [15:0] ghup_div_t;
   function automatic ghup_div_t ghup_rate_div(input logic [2:0] sel);
      case (sel)
         3'h0: ghup_rate_div = `GHUP_DIV_9600;
         3'h1: ghup_rate_div = `GHUP_DIV_38400;
         3'h2: ghup_rate_div = `GHUP_DIV_115200;
         3'h3: ghup_rate_div = `GHUP_DIV_230400;
         3'h4: ghup_rate_div = `GHUP_DIV_460800;
         3'h5: ghup_rate_div = `GHUP_DIV_1000000;
         3'h6: ghup_rate_div = `GHUP_DIV_2000000;
         default: ghup_rate_div = `GHUP_DIV_115200;
      endcase
   endfunction : ghup_rate_div
endpackage : ghup_pkg

// file: core/ghup_rx.sv
// Purpose: serial character receiver
// Assumes: line already synchronised to clk_i
// Notes: samples at mid bit; a low stop bit flags a framing error
`timescale 1ns/100ps
`include "ghup_map.svh"
module ghup_rx import ghup_pkg::*; (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic line_i,
   input wire ghup_div_t div_i,
   output logic [7:0] data_o,
   output logic valid_o,
   output logic frame_err_o
);
   ghup_state_e state_reg, state_next;
   ghup_div_t cnt_reg, cnt_next;
   logic [2:0] bit_reg, bit_next;
   logic [7:0] sh_reg, sh_next;
   logic valid_reg, valid_next;
   logic err_reg, err_next;

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      valid_next = 1'b0;
      err_next = 1'b0;
      case (state_reg)
         ghup_idle: begin
            if (!line_i) begin
               state_next = ghup_start;
               cnt_next = div_i >> 1;
            end
         end
         ghup_start: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 16'h0001;
            end else if (line_i) begin
               state_next = ghup_idle;
            end else begin
               state_next = ghup_data;
               cnt_next = div_i - 16'h0001;
               bit_next = 3'h0;
            end
         end
         ghup_data: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 16'h0001;
            end else begin
               // RULE11: lsb first
               sh_next = {line_i, sh_reg[7:1]};
               cnt_next = div_i - 16'h0001;
               bit_next = bit_reg + 3'h1;
               if (bit_reg == 3'h7) begin
                  state_next = ghup_stop;
               end
            end
         end
         ghup_stop: begin
            if (cnt_reg != '0) begin
               cnt_next = cnt_reg - 16'h0001;
            end else begin
               // RULE11: stop bit check
               state_next = ghup_idle;
               valid_next = line_i;
               err_next = !line_i;
            end
         end
         default: state_next = ghup_idle;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state_reg <= ghup_idle;
         cnt_reg <= '0;
         bit_reg <= 3'h0;
         sh_reg <= 8'h00;
         valid_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         valid_reg <= valid_next;
         err_reg <= err_next;
      end
   end

   assign data_o = sh_reg;
   assign valid_o = valid_reg;
   assign frame_err_o = err_reg;
endmodule : ghup_rx

// file: verification/ghup_port_sva.sv
// Purpose: checker on the ghup_port pins
// Assumes: bound to every ghup_port instance
// Notes: pulse width is counted, too long for a repetition
`timescale 1ns/100ps
module ghup_port_sva #(
   parameter int PPS_HIGH_CYCLES = 20
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic reset_in_low_i,
   input wire logic host_receive_line_o,
   input wire logic tx_valid_i,
   input wire logic tx_ready_o,
   input wire logic cmd_valid_o,
   input wire logic cmd_frame_err_o,
   input wire logic fix_3d_i,
   input wire logic [3:0] sat_count_i,
   input wire logic utc_second_i,
   input wire logic pps_o,
   input wire logic engine_reset_n_o
);
   logic [31:0] hi_reg;
   logic [31:0] hi_next;
   always_comb begin
      hi_next = pps_o ? hi_reg + 32'h0000_0001 : 32'h0000_0000;
   end
   always_ff @(posedge clk_i) begin
      hi_reg <= hi_next;
   end
   default clocking cb @(posedge clk_i);
   endclocking
   a_reset_level: assert property (
      !nrst_i |=> host_receive_line_o && !pps_o && !tx_ready_o && !engine_reset_n_o)
      else $error("outputs off reset level");
   a_start_low: assert property (disable iff (!nrst_i)
      tx_valid_i && tx_ready_o |=> (!host_receive_line_o && !tx_ready_o)[*8])
      else $error("start bit missing");
   a_stop_high: assert property (disable iff (!nrst_i)
      $rose(tx_ready_o) |-> host_receive_line_o && $past(host_receive_line_o))
      else $error("stop bit low");
   a_ready_idle: assert property (disable iff (!nrst_i)
      tx_ready_o |-> host_receive_line_o) else $error("idle line low");
   a_pps_fix: assert property (disable iff (!nrst_i)
      utc_second_i && fix_3d_i && sat_count_i >= 4'h4 && engine_reset_n_o |=> pps_o)
      else $error("pulse missing");
   a_pps_few_sats: assert property (disable iff (!nrst_i)
      utc_second_i && sat_count_i < 4'h4 && !pps_o |=> !pps_o) else $error("pulse too few");
   a_pps_nofix: assert property (disable iff (!nrst_i)
      !fix_3d_i |=> !pps_o) else $error("pulse without fix");
   a_pps_width: assert property (disable iff (!nrst_i)
      pps_o |-> hi_reg < 32'(PPS_HIGH_CYCLES)) else $error("pulse too long");
   a_pin_reset: assert property (disable iff (!nrst_i)
      (!reset_in_low_i)[*4] |=> !engine_reset_n_o && !tx_ready_o) else $error("pin ignored");
   a_cmd_pulse: assert property (disable iff (!nrst_i)
      cmd_valid_o |=> !cmd_valid_o) else $error("valid too long");
   a_err_drop: assert property (disable iff (!nrst_i)
      cmd_frame_err_o |-> !cmd_valid_o) else $error("bad byte passed");
endmodule : ghup_port_sva
bind ghup_port ghup_port_sva #(.PPS_HIGH_CYCLES(PPS_HIGH_CYCLES)) u_sva (.clk_i, .nrst_i,
   .reset_in_low_i, .host_receive_line_o, .tx_valid_i, .tx_ready_o, .cmd_valid_o,
   .cmd_frame_err_o, .fix_3d_i, .sat_count_i, .utc_second_i, .pps_o, .engine_reset_n_o);

// file: verification/ghup_host.sv
// Purpose: host terminal on the far side of the serial lines
// Assumes: bench sets the same divisor at both ends
// Notes: clock error of a real host is not modelled
`timescale 1ns/100ps
module ghup_host import ghup_pkg::*; (
   input wire logic clk_i,
   input wire logic line_i,
   input wire ghup_div_t div_i,
   output logic line_o,
   output logic [7:0] rx_data_o,
   output logic rx_stop_o,
   output logic rx_stb_o
);
   initial begin
      line_o = 1'b1;
      rx_stb_o = 1'b0;
   end
   task automatic send_byte(input logic [7:0] b, input logic stop);
      logic [10:0] f;
      f = {1'b1, stop, b, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_o = f[i];
         repeat (div_i) @(posedge clk_i);
         #1;
      end
   endtask : send_byte
   always begin
      logic [7:0] d;
      @(posedge clk_i);
      while (line_i !== 1'b0) @(posedge clk_i);
      repeat (div_i / 2) @(posedge clk_i);
      if (line_i === 1'b0) begin
         for (int i = 0; i < 8; i++) begin
            repeat (div_i) @(posedge clk_i);
            d[i] = line_i;
         end
         repeat (div_i) @(posedge clk_i);
         rx_data_o <= d;
         rx_stop_o <= line_i;
         rx_stb_o <= 1'b1;
         @(posedge clk_i);
         rx_stb_o <= 1'b0;
      end
   end
endmodule : ghup_host

// file: verification/ghup_port_bench.sv
// Purpose: self-checking bench for ghup_port
// Assumes: host model on the lines, pulse width cut to 20 cycles
// Notes: 9600 left out, one character costs 130k cycles
`timescale 1ns/100ps
module ghup_port_bench;
   localparam int HI = 20;
   int rt[7] = '{9600, 38400, 115200, 230400, 460800, 1000000, 2000000};
   logic clk_i = 1'b0, nrst_i = 1'b0, reset_in_low_i = 1'b1, rate_load_i = 1'b0;
   logic tx_valid_i = 1'b0, fix_3d_i = 1'b0, utc_second_i = 1'b0;
   logic [2:0] rate_sel_i = 3'h2;
   logic [7:0] tx_data_i = 8'h00, cmd_data_o, rx_data;
   logic [3:0] sat_count_i = 4'h0;
   logic host_transmit_line_i, host_receive_line_o, tx_ready_o, cmd_valid_o, cmd_frame_err_o;
   logic pps_o, engine_reset_n_o, rx_stop, rx_stb;
   logic [15:0] host_div = 16'h0000;
   logic [8:0] exp_tx[$], exp_cmd[$];
   int bad_count = 0, n_compared = 0, w;
   integer seed = 32'hbff9;
   always #4 clk_i = ~clk_i;
   ghup_port #(.PPS_HIGH_CYCLES(HI)) dut (.clk_i, .nrst_i, .reset_in_low_i,
      .host_transmit_line_i, .host_receive_line_o, .rate_sel_i, .rate_load_i, .tx_data_i,
      .tx_valid_i, .tx_ready_o, .cmd_data_o, .cmd_valid_o, .cmd_frame_err_o, .fix_3d_i,
      .sat_count_i, .utc_second_i, .pps_o, .engine_reset_n_o);
   ghup_host host (.clk_i, .line_i(host_receive_line_o), .div_i(host_div),
      .line_o(host_transmit_line_i), .rx_data_o(rx_data), .rx_stop_o(rx_stop), .rx_stb_o(rx_stb));
   task automatic check(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   // no buffer, so the byte waits on ready
   task automatic send_dev(input logic last);
      tx_data_i = 8'($random(seed));
      exp_tx.push_back({1'b1, tx_data_i});
      tx_valid_i = 1'b1;
      for (int i = 0; i < 40000 && tx_ready_o !== 1'b1; i++) tick(1);
      tick(1);
      if (last)
         tx_valid_i = 1'b0;
   endtask : send_dev
   task automatic send_host(input logic stop);
      logic [7:0] b;
      b = 8'($random(seed));
      exp_cmd.push_back(stop ? {1'b0, b} : 9'h100);
      host.send_byte(b, stop);
   endtask : send_host
   task automatic set_rate(input int k);
      rate_sel_i = 3'(k);
      rate_load_i = 1'b1;
      host_div = 16'((125000000 + rt[k] / 2) / rt[k]);
      tick(1);
      rate_load_i = 1'b0;
   endtask : set_rate
   task automatic both();
      fork
         send_dev(1'b1);
         send_host(1'b1);
      join
      for (int i = 0; i < 40000 && exp_tx.size() + exp_cmd.size() > 0; i++) tick(1);
      check("left", 9'(exp_tx.size() + exp_cmd.size()), 9'h000);
   endtask : both
   task automatic pulse_sec();
      utc_second_i = 1'b1;
      tick(1);
      utc_second_i = 1'b0;
   endtask : pulse_sec
   always @(posedge clk_i) begin
      if (rx_stb)
         check("host byte", {rx_stop, rx_data},
            exp_tx.size() ? exp_tx.pop_front() : 9'h1ff);
      if (cmd_valid_o || cmd_frame_err_o)
         check("cmd", cmd_frame_err_o ? 9'h100 : {1'b0, cmd_data_o},
            exp_cmd.size() ? exp_cmd.pop_front() : 9'h1ff);
   end
   initial begin
      host_div = 16'((125000000 + rt[2] / 2) / rt[2]);
      tick(10);
      nrst_i = 1'b1;
      tick(4);
      check("idle", {7'h00, host_receive_line_o, tx_ready_o}, 9'h003);
      both();
      reset_in_low_i = 1'b0;
      tick(4);
      check("pin low", {7'h00, engine_reset_n_o, tx_ready_o}, 9'h000);
      reset_in_low_i = 1'b1;
      tick(6);
      check("pin high", {7'h00, engine_reset_n_o, tx_ready_o}, 9'h003);
      for (int k = 1; k < 7; k++) begin
         if (k != 2) begin
            set_rate(k);
            both();
         end
      end
      fork
         begin
            send_dev(1'b0);
            send_dev(1'b1);
         end
         send_host(1'b0);
      join
      both();
      // code 7 names no rate, so the port must stay at 2000000
      rate_sel_i = 3'h7;
      rate_load_i = 1'b1;
      tick(1);
      rate_load_i = 1'b0;
      both();
      fix_3d_i = 1'b1;
      sat_count_i = 4'h4 + 4'({$random(seed)} % 12);
      pulse_sec();
      check("pps rise", {8'h00, pps_o}, 9'h001);
      w = 0;
      while (pps_o === 1'b1 && w < 100) begin
         w++;
         tick(1);
      end
      check("pps width", 9'(w), 9'(HI));
      sat_count_i = 4'h3;
      pulse_sec();
      check("pps few", {8'h00, pps_o}, 9'h000);
      sat_count_i = 4'hf;
      pulse_sec();
      tick(3);
      fix_3d_i = 1'b0;
      tick(1);
      check("pps lost", {8'h00, pps_o}, 9'h000);
      pulse_sec();
      check("pps nofix", {8'h00, pps_o}, 9'h000);
      end_sim();
   end
   initial begin
      tick(90000);
      bad_count++;
      end_sim();
   end
endmodule : ghup_port_bench
